// ---- hw/remote_control_arbiter.sv ----
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Purpose: control location arbiter with supervision and analog scaling
// Assumes: analog codes sampled on clk_i; pins asynchronous
// Notes: registers on classic Wishbone, one cycle to ack
module remote_control_arbiter #(
  parameter logic [31:0] SUP_TICKS_RST = rc_pkg::SUP_DEF_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [rc_pkg::N_DIG-1:0] dig_req_i,
  input wire logic [rc_pkg::N_DIG-1:0] dig_rel_i,
  input wire logic [rc_pkg::N_DIG-1:0] dig_msg_i,
  output logic [rc_pkg::N_DIG-1:0] dig_err_o,
  output logic [rc_pkg::N_DIG-1:0] dig_grant_o,
  input wire logic remote_select_n_i,
  input wire logic resistance_mode_i,
  input wire logic output_standby_pin_i,
  input wire logic [rc_pkg::VW-1:0] voltage_setpoint_in_i,
  input wire logic [rc_pkg::VW-1:0] current_setpoint_in_i,
  input wire logic [rc_pkg::VW-1:0] power_setpoint_in_i,
  input wire logic [rc_pkg::VW-1:0] resistance_setpoint_in_i,
  input wire logic [rc_pkg::VW-1:0] panel_u_i,
  input wire logic [rc_pkg::VW-1:0] panel_i_i,
  input wire logic [rc_pkg::VW-1:0] panel_p_i,
  input wire logic [rc_pkg::VW-1:0] panel_r_i,
  input wire logic [rc_pkg::VW-1:0] actual_u_i,
  input wire logic [rc_pkg::VW-1:0] actual_i_i,
  output logic [rc_pkg::VW-1:0] voltage_monitor_out_o,
  output logic [rc_pkg::VW-1:0] current_monitor_out_o,
  output logic [rc_pkg::VW-1:0] reference_out_o,
  output logic [rc_pkg::VW-1:0] set_u_o,
  output logic [rc_pkg::VW-1:0] set_i_o,
  output logic [rc_pkg::VW-1:0] set_p_o,
  output logic [rc_pkg::VW-1:0] set_r_o,
  output logic resistance_mode_o,
  output logic dc_output_o,
  output logic remote_o,
  output logic local_o,
  output logic analog_active_o
);
  import rc_pkg::*;

  function automatic logic [VW-1:0] clip_val(input logic [VW-1:0] v,
                                             input logic [VW-1:0] lim);
    clip_val = (v > lim) ? lim : v;
  endfunction

  // pin code to fraction of nominal; 5 V range doubles, saturating
  function automatic logic [VW-1:0] scale_in(input logic [VW-1:0] code,
                                             input logic r10);
    if (r10) begin
      scale_in = code;
    end else if (code[VW-1]) begin
      scale_in = VREF_10V_CODE;
    end else begin
      scale_in = {code[VW-2:0], 1'b0};
    end
  endfunction

  function automatic logic [VW-1:0] scale_mon(input logic [VW-1:0] v,
                                              input logic r10);
    scale_mon = r10 ? v : {1'b0, v[VW-1:1]};
  endfunction

  function automatic logic [HOLDER_W-1:0] lowest(
      input logic [N_DIG-1:0] v);
    lowest = '0;
    for (int k = N_DIG - 1; k >= 0; k--) begin
      if (v[k]) begin
        lowest = HOLDER_W'(k);
      end
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // pin synchronisers
  logic [2:0] pin_raw;
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  assign pin_raw = {output_standby_pin_i, resistance_mode_i,
                    remote_select_n_i};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_meta_q[g] <= PIN_RST[g];
          pin_sync_q[g] <= PIN_RST[g];
        end else begin
          pin_meta_q[g] <= pin_raw[g];
          pin_sync_q[g] <= pin_meta_q[g];
        end
      end
    end
  endgenerate

  logic remote_req;
  logic rmode_on;
  logic standby_on;
  assign remote_req = !pin_sync_q[0];
  assign rmode_on = pin_sync_q[1];
  assign standby_on = pin_sync_q[2];

  // register state
  logic [3:0] ctrl_q;
  logic dc_on_q;
  logic [31:0] tmo_q;
  logic [1:0] ev_q;
  logic [31:0] lim_ui_q;
  logic [31:0] lim_pr_q;
  logic [31:0] dig_ui_q;
  logic [31:0] dig_pr_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic wb_req;
  logic wr_en;
  logic wr_ctrl;
  logic [ADDR_W-1:0] adr;
  logic allow;
  logic range10;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wr_en = ack_q && wb_req && wb_we_i;
  assign adr = {wb_adr_i[ADDR_W-1:2], 2'b00};
  assign wr_ctrl = wr_en && adr == ADDR_CTRL;
  assign allow = ctrl_q[CTRL_ALLOW];
  assign range10 = ctrl_q[CTRL_RANGE10];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // location state machine
  loc_t loc_q;
  logic [HOLDER_W-1:0] holder_q;
  logic [HOLDER_W-1:0] req_idx;
  logic grant_take;
  logic holder_msg;
  logic holder_rel;
  logic sup_expired;
  logic [N_DIG-1:0] err_d;
  logic [N_DIG-1:0] err_q;
  sup_if sup ();

  assign req_idx = lowest(dig_req_i);
  // analog pin wins a tie with a digital request
  assign grant_take = loc_q == LOC_MANUAL && allow && !remote_req &&
                      |dig_req_i;
  assign holder_msg = loc_q == LOC_DIGITAL && dig_msg_i[holder_q];
  assign holder_rel = loc_q == LOC_DIGITAL && dig_rel_i[holder_q];
  assign sup_expired = sup.expired;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loc_q <= LOC_MANUAL;
      holder_q <= '0;
    end else begin
      unique case (loc_q)
        LOC_MANUAL: begin
          if (!allow) begin
            loc_q <= LOC_LOCKED;
          end else if (remote_req) begin
            loc_q <= LOC_ANALOG;
          end else if (grant_take) begin
            loc_q <= LOC_DIGITAL;
            holder_q <= req_idx;
          end
        end
        LOC_DIGITAL: begin
          if (!allow) begin
            loc_q <= LOC_LOCKED;
          end else if (sup_expired || holder_rel) begin
            loc_q <= LOC_MANUAL;
          end
        end
        LOC_ANALOG: begin
          if (!allow) begin
            loc_q <= LOC_LOCKED;
          end else if (!remote_req) begin
            loc_q <= LOC_MANUAL;
          end
        end
        LOC_LOCKED: begin
          if (allow) begin
            loc_q <= remote_req ? LOC_ANALOG : LOC_MANUAL;
          end
        end
        default: loc_q <= LOC_MANUAL;
      endcase
    end
  end

  generate
    for (g = 0; g < N_DIG; g++) begin : g_port
      assign err_d[g] = dig_req_i[g] &&
        !(grant_take && req_idx == HOLDER_W'(g)) &&
        !(loc_q == LOC_DIGITAL && holder_q == HOLDER_W'(g));
      assign dig_grant_o[g] = loc_q == LOC_DIGITAL &&
                              holder_q == HOLDER_W'(g);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end
  assign dig_err_o = err_q;

  // supervision watches the holder only; network timeout stays apart
  assign sup.enable = ctrl_q[CTRL_SUP_EN] && loc_q == LOC_DIGITAL;
  assign sup.restart = holder_msg || grant_take;
  assign sup.pending = tmo_q;

  supervision_timer #(.RST_TICKS(SUP_TICKS_RST)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sup(sup)
  );

  // register bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      tmo_q <= SUP_TICKS_RST;
      lim_ui_q <= LIM_RST;
      lim_pr_q <= LIM_RST;
      dig_ui_q <= DIG_RST;
      dig_pr_q <= DIG_RST;
    end else if (wr_en) begin
      if (adr == ADDR_CTRL && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[3:0];
      end
      if (adr == ADDR_TIMEOUT) begin
        tmo_q <= merge(tmo_q, wb_dat_i, wb_sel_i);
      end
      if (adr == ADDR_LIM_UI) begin
        lim_ui_q <= merge(lim_ui_q, wb_dat_i, wb_sel_i);
      end
      if (adr == ADDR_LIM_PR) begin
        lim_pr_q <= merge(lim_pr_q, wb_dat_i, wb_sel_i);
      end
      if (adr == ADDR_DIG_UI) begin
        dig_ui_q <= merge(dig_ui_q, wb_dat_i, wb_sel_i);
      end
      if (adr == ADDR_DIG_PR) begin
        dig_pr_q <= merge(dig_pr_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // expiry beats a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dc_on_q <= 1'b0;
    end else if (sup_expired && loc_q == LOC_DIGITAL &&
                 !ctrl_q[CTRL_KEEP_ON]) begin
      dc_on_q <= 1'b0;
    end else if (wr_ctrl && wb_sel_i[0]) begin
      dc_on_q <= wb_dat_i[CTRL_DC_ON];
    end
  end

  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  assign ev_set = {|err_d, sup_expired && loc_q == LOC_DIGITAL};
  assign ev_clr = (wr_en && adr == ADDR_EVENT && wb_sel_i[0]) ?
                  wb_dat_i[1:0] : 2'b00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_q <= 2'b00;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  // status and applied set value reads depend on who holds control
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    unique case (adr)
      ADDR_CTRL: rdata = {27'h0, dc_on_q, ctrl_q};
      ADDR_TIMEOUT: rdata = tmo_q;
      ADDR_STATUS: begin
        rdata[ST_LOC +: 4] = loc_q;
        rdata[ST_HOLDER +: HOLDER_W] = holder_q;
        rdata[ST_DC] = dc_output_o;
        rdata[ST_RMODE] = resistance_mode_o;
        rdata[ST_SUP_RUN] = sup.running;
      end
      ADDR_EVENT: rdata = {30'h0, ev_q};
      ADDR_LIM_UI: rdata = lim_ui_q;
      ADDR_LIM_PR: rdata = lim_pr_q;
      ADDR_DIG_UI: rdata = dig_ui_q;
      ADDR_DIG_PR: rdata = dig_pr_q;
      ADDR_APP_UI: rdata = {set_i_o, set_u_o};
      ADDR_APP_PR: rdata = {set_r_o, set_p_o};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (wb_req && !ack_q) begin
      dat_q <= wb_we_i ? 32'h0 : rdata;
    end
  end

  // applied set values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_u_o <= '0;
      set_i_o <= '0;
      set_p_o <= '0;
      set_r_o <= '0;
      resistance_mode_o <= 1'b0;
    end else if (loc_q == LOC_ANALOG) begin
      set_u_o <= clip_val(scale_in(voltage_setpoint_in_i, range10),
                          lim_ui_q[VW-1:0]);
      set_i_o <= clip_val(scale_in(current_setpoint_in_i, range10),
                          lim_ui_q[31:VW]);
      set_p_o <= clip_val(scale_in(power_setpoint_in_i, range10),
                          lim_pr_q[VW-1:0]);
      set_r_o <= rmode_on ?
        clip_val(scale_in(resistance_setpoint_in_i, range10),
                 lim_pr_q[31:VW]) :
        clip_val(panel_r_i, lim_pr_q[31:VW]);
      resistance_mode_o <= rmode_on;
    end else begin
      set_u_o <= clip_val(loc_q == LOC_DIGITAL ? dig_ui_q[VW-1:0] :
                          panel_u_i, lim_ui_q[VW-1:0]);
      set_i_o <= clip_val(loc_q == LOC_DIGITAL ? dig_ui_q[31:VW] :
                          panel_i_i, lim_ui_q[31:VW]);
      set_p_o <= clip_val(loc_q == LOC_DIGITAL ? dig_pr_q[VW-1:0] :
                          panel_p_i, lim_pr_q[VW-1:0]);
      set_r_o <= clip_val(loc_q == LOC_DIGITAL ? dig_pr_q[31:VW] :
                          panel_r_i, lim_pr_q[31:VW]);
      resistance_mode_o <= 1'b0;
    end
  end

  // monitors, reference and indicators
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      voltage_monitor_out_o <= '0;
      current_monitor_out_o <= '0;
      reference_out_o <= VREF_10V_CODE;
    end else begin
      voltage_monitor_out_o <= scale_mon(actual_u_i, range10);
      current_monitor_out_o <= scale_mon(actual_i_i, range10);
      reference_out_o <= range10 ? VREF_10V_CODE : VREF_5V_CODE;
    end
  end

  // standby pin acts in every location
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dc_output_o <= 1'b0;
      remote_o <= 1'b0;
      local_o <= 1'b0;
      analog_active_o <= 1'b0;
    end else begin
      dc_output_o <= dc_on_q && standby_on;
      remote_o <= loc_d_remote(loc_q);
      local_o <= loc_q == LOC_LOCKED;
      analog_active_o <= loc_q == LOC_ANALOG;
    end
  end

  function automatic logic loc_d_remote(input loc_t l);
    loc_d_remote = l == LOC_DIGITAL || l == LOC_ANALOG;
  endfunction

  single_holder_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(dig_grant_o) && !(loc_q == LOC_ANALOG && |dig_grant_o))
    else $error("two remote sources hold control");

  analog_reject_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      loc_q == LOC_ANALOG && dig_req_i[0] |=> dig_err_o[0])
    else $error("digital request under analog control not refused");

  pin_ignored_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      loc_q == LOC_DIGITAL && allow && !sup_expired && !holder_rel
      |=> loc_q == LOC_DIGITAL)
    else $error("digital control left without cause");

  lock_enter_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      !allow |=> loc_q == LOC_LOCKED ##1 local_o)
    else $error("local lock not entered or not shown");

  lock_ends_dig_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      loc_q == LOC_LOCKED && allow |=> loc_q != LOC_DIGITAL)
    else $error("digital control restored without new request");

  analog_resume_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      loc_q == LOC_LOCKED && allow && remote_req |=> loc_q == LOC_ANALOG)
    else $error("analog control not resumed after lock");

  sup_holder_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sup.running |-> loc_q == LOC_DIGITAL)
    else $error("supervision running outside digital control");

  timeout_exit_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sup_expired && loc_q == LOC_DIGITAL && allow |=>
      loc_q == LOC_MANUAL &&
      dc_on_q == ($past(dc_on_q) && $past(ctrl_q[CTRL_KEEP_ON])))
    else $error("timeout reaction wrong");

  limit_clip_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $stable(lim_ui_q) |-> set_u_o <= lim_ui_q[VW-1:0])
    else $error("voltage set value above its limit");

  ref_range_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(range10) |=> reference_out_o ==
      ($past(range10) ? VREF_10V_CODE : VREF_5V_CODE))
    else $error("reference output does not follow range");

  ack_pulse_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  grant_c: cover property (@(posedge clk_i) disable iff (rst_i)
    grant_take ##1 loc_q == LOC_DIGITAL);
  timeout_c: cover property (@(posedge clk_i) disable iff (rst_i)
    sup_expired && loc_q == LOC_DIGITAL);
  analog_c: cover property (@(posedge clk_i) disable iff (rst_i)
    loc_q == LOC_ANALOG && dig_err_o[0]);
  resume_c: cover property (@(posedge clk_i) disable iff (rst_i)
    loc_q == LOC_LOCKED ##1 loc_q == LOC_ANALOG);
endmodule // remote_control_arbiter

// ---- hw/supervision_timer.sv ----
`timescale 1ns/1ps
// Purpose: communication supervision countdown
// Assumes: restart and enable from logic on clk_i
// Notes: a zero timeout acts as one tick
module supervision_timer #(
  parameter logic [31:0] RST_TICKS = rc_pkg::SUP_DEF_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sup_if.timer sup
);
  import rc_pkg::*;
  logic [31:0] active_q;
  logic [31:0] count_q;
  logic expired_q;
  logic expire_now;

  assign expire_now = sup.enable && !sup.restart && (count_q <= 32'h1);
  assign sup.expired = expired_q;
  assign sup.running = sup.enable;

  // interval length switches only between intervals
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= RST_TICKS;
    end else if (!sup.enable || expire_now) begin
      active_q <= sup.pending;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= RST_TICKS;
    end else if (!sup.enable || expire_now) begin
      count_q <= sup.pending;
    end else if (sup.restart) begin
      count_q <= active_q;
    end else begin
      count_q <= count_q - 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= expire_now;
    end
  end

  timer_reload_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sup.enable && sup.restart |=> count_q == $past(active_q))
    else $error("restart did not reload the running interval");

  timer_hold_a:
    assert property (@(posedge clk_i) disable iff (rst_i)
      sup.enable && !expire_now |=> $stable(active_q))
    else $error("interval length changed mid interval");
endmodule // supervision_timer

// ---- shared/rc_pkg.sv ----
// Purpose: constants, register map and types of the remote control arbiter
// Assumes: 250 MHz device clock, classic Wishbone register access
// Notes: pin codes are 16 bit, 16'hFFFF stands for 10 V on the pin
package rc_pkg;
  localparam int N_DIG = 2;
  localparam int HOLDER_W = 1;
  localparam int VW = 16;
  localparam int ADDR_W = 8;
  localparam int CLK_MHZ = 250;
  localparam int SUP_DEF_MS = 1000;
  localparam logic [31:0] SUP_DEF_TICKS = 32'(SUP_DEF_MS * CLK_MHZ * 1000);

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LIM_UI = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LIM_PR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_DIG_UI = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_DIG_PR = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_APP_UI = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_APP_PR = 8'h24;

  localparam int CTRL_ALLOW = 0;
  localparam int CTRL_RANGE10 = 1;
  localparam int CTRL_KEEP_ON = 2;
  localparam int CTRL_SUP_EN = 3;
  localparam int CTRL_DC_ON = 4;
  localparam logic [3:0] CTRL_RST = 4'h3;

  localparam int ST_LOC = 0;
  localparam int ST_HOLDER = 4;
  localparam int ST_DC = 8;
  localparam int ST_RMODE = 9;
  localparam int ST_SUP_RUN = 10;

  localparam int EV_TIMEOUT = 0;
  localparam int EV_REJECT = 1;

  localparam logic [31:0] LIM_RST = 32'hFFFFFFFF;
  localparam logic [31:0] DIG_RST = 32'h00000000;
  localparam logic [2:0] PIN_RST = 3'h1;
  localparam logic [VW-1:0] VREF_5V_CODE = 16'h7FFF;
  localparam logic [VW-1:0] VREF_10V_CODE = 16'hFFFF;

  typedef enum logic [3:0] {
    LOC_MANUAL = 4'b0001,
    LOC_DIGITAL = 4'b0010,
    LOC_ANALOG = 4'b0100,
    LOC_LOCKED = 4'b1000
  } loc_t;
endpackage

// ---- shared/sup_if.sv ----
`timescale 1ns/1ps
// Purpose: link between arbiter and supervision timer
// Assumes: both ends on clk_i
// Notes: pending is the software timeout in clock ticks
interface sup_if;
  logic enable;
  logic restart;
  logic [31:0] pending;
  logic expired;
  logic running;
  modport ctrl (output enable, output restart, output pending,
                input expired, input running);
  modport timer (input enable, input restart, input pending,
                 output expired, output running);
endinterface

// ---- test/ctrl_host.sv ----
// Purpose: model of the external controller, digital ports and pins
// Assumes: tasks are called from the bench, clk_i domain
// Notes: released setpoint lines show the inverse code
`timescale 1ns/1ps
module ctrl_host (
  input wire logic clk_i,
  output logic [1:0] req_o,
  output logic [1:0] rel_o,
  output logic [1:0] msg_o,
  output logic remote_n_o,
  output logic standby_o,
  output logic rmode_o,
  output logic [15:0] code_o
);
  logic [5:0] p_q = 6'h00;
  logic sel_n_q = 1'b1;
  logic [15:0] code_q = 16'h0000;
  logic sb_q = 1'b1;
  logic rm_q = 1'b0;
  assign {msg_o, rel_o, req_o} = p_q;
  assign remote_n_o = sel_n_q;
  assign standby_o = sb_q;
  assign rmode_o = rm_q;
  assign code_o = sel_n_q ? ~code_q : code_q;
  // bits 0..1 request, 2..3 release, 4..5 message
  task pulse(input int b);
    @(posedge clk_i);
    p_q[b] <= 1'b1;
    @(posedge clk_i);
    p_q[b] <= 1'b0;
  endtask
  // drives the setpoint code and the remote select pin in the same cycle
  task analog(input logic on, input logic [15:0] c);
    @(posedge clk_i);
    code_q <= c;
    sel_n_q <= ~on;
  endtask
  // standby and resistance mode pins, both slow levels
  task pins(input logic sb, input logic rm);
    @(posedge clk_i);
    sb_q <= sb;
    rm_q <= rm;
  endtask
endmodule // ctrl_host

// ---- test/remote_control_arbiter_bench.sv ----
// Purpose: self-checking bench of the control location arbiter
// Assumes: 250 MHz clock, short supervision reset count
// Notes: one task per scenario
`timescale 1ns/1ps
module remote_control_arbiter_bench;
  import rc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, remote_select_n_i, resistance_mode_i;
  logic output_standby_pin_i, resistance_mode_o, dc_output_o;
  logic remote_o, local_o, analog_active_o;
  logic [1:0] dig_req_i, dig_rel_i, dig_msg_i, dig_err_o, dig_grant_o;
  logic [15:0] voltage_setpoint_in_i, current_setpoint_in_i;
  logic [15:0] power_setpoint_in_i, resistance_setpoint_in_i;
  logic [15:0] panel_u_i = 16'h1234, panel_i_i = 16'h1234;
  logic [15:0] panel_p_i = 16'h1234, panel_r_i = 16'h1234;
  logic [15:0] actual_u_i = 16'h6000, actual_i_i = 16'h2000;
  logic [15:0] voltage_monitor_out_o, current_monitor_out_o;
  logic [15:0] reference_out_o, set_u_o, set_i_o, set_p_o, set_r_o;
  int errors = 0, total_checks = 0;
  always #2 clk_i = ~clk_i;
  assign {current_setpoint_in_i, power_setpoint_in_i,
          resistance_setpoint_in_i} = {3{voltage_setpoint_in_i}};
  remote_control_arbiter #(.SUP_TICKS_RST(32'h14)) i_dut (.*);
  ctrl_host i_pc (.clk_i(clk_i), .req_o(dig_req_i), .rel_o(dig_rel_i),
    .msg_o(dig_msg_i), .remote_n_o(remote_select_n_i),
    .standby_o(output_standby_pin_i), .rmode_o(resistance_mode_i),
    .code_o(voltage_setpoint_in_i));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s = 4'hF);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) errors++;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task t_grant;
    i_pc.pulse(0);
    #1;
    chk("grant", 1, dig_grant_o);
    i_pc.pulse(1);
    #1;
    chk("err", 2, dig_err_o);
    wb(0, ADDR_STATUS, 0);
    chk("loc", LOC_DIGITAL, rd[3:0]);
    i_pc.pulse(2);
    #1;
    chk("rel", 0, dig_grant_o);
    wb(0, 8'hF0, 0);
    chk("unmap", 0, rd);
  endtask
  task t_analog;
    actual_i_i <= 16'h4000;
    i_pc.analog(1, 16'h4000);
    cyc(5);
    chk("ana", 1, analog_active_o);
    chk("setu", 16'h4000, set_u_o);
    chk("setp", 16'h4000, set_p_o);
    chk("setr", 16'h1234, set_r_o);
    i_pc.pins(1, 1);
    cyc(4);
    chk("rmode", 1, resistance_mode_o);
    chk("rset", 16'h4000, set_r_o);
    i_pc.pins(1, 0);
    i_pc.pulse(0);
    #1;
    chk("rej", 1, dig_err_o);
    wb(1, ADDR_LIM_UI, 32'h00002000, 4'h3);
    cyc(3);
    chk("clip", 16'h2000, set_u_o);
    chk("seti", 16'h4000, set_i_o);
    wb(1, ADDR_LIM_UI, 32'hFFFFFFFF);
    wb(1, ADDR_CTRL, 32'h1);
    cyc(3);
    chk("vref5", 16'h7FFF, reference_out_o);
    chk("set5", 16'h8000, set_u_o);
    chk("mon5", 16'h3000, voltage_monitor_out_o);
    chk("cmon5", 16'h2000, current_monitor_out_o);
    wb(1, ADDR_CTRL, 32'h0);
    cyc(3);
    chk("lock", 1, local_o);
    chk("susp", 0, analog_active_o);
    wb(1, ADDR_CTRL, 32'h3);
    cyc(3);
    chk("resume", 1, analog_active_o);
    chk("vref10", 16'hFFFF, reference_out_o);
    chk("cmon10", 16'h4000, current_monitor_out_o);
    i_pc.analog(0, 16'h4000);
    cyc(5);
    chk("man", 0, remote_o);
  endtask
  task t_dig;
    i_pc.pulse(0);
    i_pc.analog(1, 16'h4000);
    cyc(5);
    chk("pinign", 0, analog_active_o);
    wb(0, ADDR_STATUS, 0);
    chk("stat", LOC_DIGITAL, rd[3:0]);
    i_pc.analog(0, 16'h4000);
    wb(1, ADDR_CTRL, 32'h2);
    cyc(2);
    chk("drop", 0, dig_grant_o);
    wb(1, ADDR_CTRL, 32'h3);
    cyc(2);
    chk("noreg", 0, dig_grant_o);
  endtask
  task t_sup;
    wb(1, ADDR_TIMEOUT, 32'h8);
    wb(1, ADDR_CTRL, 32'h1B);
    i_pc.pulse(0);
    repeat (4) begin
      cyc(4);
      i_pc.pulse(4);
    end
    #1;
    chk("alive", 1, dig_grant_o);
    chk("dcon", 1, dc_output_o);
    cyc(12);
    chk("tmo", 0, dig_grant_o);
    chk("dcoff", 0, dc_output_o);
    wb(0, ADDR_EVENT, 0);
    chk("ev", 1, rd[0]);
    wb(1, ADDR_CTRL, 32'h1F);
    i_pc.pulse(0);
    wb(1, ADDR_TIMEOUT, 32'h28);
    cyc(7);
    chk("oldtmo", 0, dig_grant_o);
    chk("keep", 1, dc_output_o);
    i_pc.pins(0, 0);
    cyc(4);
    chk("stby", 0, dc_output_o);
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(4);
    chk("ref", 16'hFFFF, reference_out_o);
    t_grant();
    t_analog();
    t_dig();
    t_sup();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule // remote_control_arbiter_bench
